// ---- verilog/sew_slave.sv ----
// Two-wire bus write slave of a 64K x 8 EEPROM: framing, addressing,
// page latch and a self-timed commit to the array write port.
// Assumes open-drain pins resolved outside and an array that takes one
// byte per asserted write enable.
`timescale 1ns/1ps
module sew_slave
    import sew_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps
    input wire logic write_control_pin,
    input wire logic chip_select_bit0,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit2,
    // Array write port
    output logic array_wr_en,
    output logic [ADDR_W-1:0] array_wr_addr,
    output logic [7:0] array_wr_data,
    // Status
    output logic busy,
    output logic standby,
    output logic [ADDR_W-1:0] word_address_bits
);

    typedef struct packed {
        sew_state_t st;
        logic scl_p;
        logic sda_p;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic ack;
        logic has_data;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_BYTES-1:0] valid;
        logic [TIMER_W-1:0] timer;
        logic [PAGE_AW:0] cidx;
        sew_wr_t wr;
    } sew_slave_state_t;

    sew_slave_state_t s_q;
    sew_slave_state_t s_d;
    sew_pins_t pin_async;
    sew_pins_t pin;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic dev_match;
    logic pl_we;
    logic [PAGE_AW-1:0] pl_waddr;
    logic [PAGE_AW-1:0] pl_raddr;
    logic [7:0] pl_rdata;

    assign pin_async.scl = scl_in;
    assign pin_async.sda = sda_in;
    assign pin_async.write_control_pin = write_control_pin;
    assign pin_async.chip_select = {chip_select_bit2, chip_select_bit1, chip_select_bit0};

    sew_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(pin_async),
        .sync_out(pin)
    );

    sew_page_mem u_page (
        .clock(clock),
        .rst(rst),
        .we(pl_we),
        .waddr(pl_waddr),
        .wdata(s_q.shift),
        .raddr(pl_raddr),
        .rdata_q(pl_rdata)
    );

    // Bus clock edges and framing events, seen on synchronised levels.
    assign scl_rise = pin.scl & ~s_q.scl_p;
    assign scl_fall = ~pin.scl & s_q.scl_p;
    assign start_seen = pin.scl & s_q.scl_p & s_q.sda_p & ~pin.sda;
    assign stop_seen = pin.scl & s_q.scl_p & ~s_q.sda_p & pin.sda;
    assign dev_match = (s_q.shift[7:4] == DEV_TYPE)
        && (s_q.shift[3:1] == pin.chip_select);

    always_comb begin
        s_d = s_q;
        s_d.scl_p = pin.scl;
        s_d.sda_p = pin.sda;
        s_d.wr.en = 1'b0;
        pl_we = 1'b0;
        pl_waddr = s_q.addr[PAGE_AW-1:0];
        pl_raddr = s_q.cidx[PAGE_AW-1:0];
        if (s_q.st == ST_PROG) begin
            // Bus is ignored here, so polls go unanswered until done.
            if (!s_q.cidx[PAGE_AW]) begin
                // Latched bytes stream out one per cycle behind the read.
                s_d.wr.en = s_q.valid[s_q.cidx[PAGE_AW-1:0]];
                s_d.wr.addr = {s_q.addr[ADDR_W-1:PAGE_AW], s_q.cidx[PAGE_AW-1:0]};
                s_d.cidx = s_q.cidx + 8'h01;
            end
            if (s_q.timer == TIMER_W'(PROG_CYCLES_P - 1)) begin
                s_d.st = ST_IDLE;
            end else begin
                s_d.timer = s_q.timer + 18'h00001;
            end
        end else if (start_seen) begin
            // Any start outside a write cycle restarts framing, which also serves recovery.
            s_d.st = ST_DEV;
            s_d.cnt = 4'h0;
            s_d.ack = 1'b0;
        end else if (stop_seen) begin
            s_d.ack = 1'b0;
            s_d.cnt = 4'h0;
            if (s_q.st == ST_DATA && s_q.has_data && !pin.write_control_pin) begin
                s_d.st = ST_PROG;
                s_d.timer = '0;
                s_d.cidx = '0;
            end else begin
                s_d.st = ST_IDLE;
            end
        end else if (s_q.st != ST_IDLE) begin
            if (scl_rise) begin
                if (s_q.cnt < BITS_PER_WORD) begin
                    s_d.shift = {s_q.shift[6:0], pin.sda};
                end
                if (s_q.cnt != ACK_CLOCK) begin
                    s_d.cnt = s_q.cnt + 4'h1;
                end
            end
            if (scl_fall && s_q.cnt == ACK_CLOCK) begin
                s_d.ack = 1'b0;
                s_d.cnt = 4'h0;
            end
            if (scl_fall && s_q.cnt == BITS_PER_WORD) begin
                unique case (s_q.st)
                    ST_DEV: begin
                        if (!dev_match) begin
                            s_d.st = ST_IDLE;
                        end else if (s_q.shift[0]) begin
                            s_d.ack = 1'b1;
                            s_d.st = ST_SKIP;
                        end else begin
                            s_d.ack = 1'b1;
                            s_d.st = ST_WHI;
                            s_d.valid = '0;
                            s_d.has_data = 1'b0;
                        end
                    end
                    ST_WHI: begin
                        s_d.addr[15:8] = s_q.shift;
                        s_d.ack = 1'b1;
                        s_d.st = ST_WLO;
                    end
                    ST_WLO: begin
                        s_d.addr[7:0] = s_q.shift;
                        s_d.ack = 1'b1;
                        s_d.st = ST_DATA;
                    end
                    ST_DATA: begin
                        // Later bytes to the same slot overwrite earlier ones.
                        pl_we = 1'b1;
                        s_d.valid[s_q.addr[PAGE_AW-1:0]] = 1'b1;
                        s_d.has_data = 1'b1;
                        s_d.addr[PAGE_AW-1:0] = s_q.addr[PAGE_AW-1:0] + 7'h01;
                        s_d.ack = 1'b1;
                    end
                    ST_SKIP: begin
                        s_d.st = ST_SKIP;
                    end
                    default: begin
                        s_d.st = ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q.st <= ST_IDLE;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.cnt <= 4'h0;
            s_q.shift <= 8'h00;
            s_q.ack <= 1'b0;
            s_q.has_data <= 1'b0;
            s_q.addr <= 16'h0000;
            s_q.valid <= '0;
            s_q.timer <= '0;
            s_q.cidx <= '0;
            s_q.wr <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = s_q.ack;
    assign array_wr_en = s_q.wr.en;
    assign array_wr_addr = s_q.wr.addr;
    assign array_wr_data = pl_rdata;
    assign busy = (s_q.st == ST_PROG);
    assign standby = (s_q.st == ST_IDLE);
    assign word_address_bits = s_q.addr;

endmodule

// ---- verilog/sew_pkg.sv ----
// Shared constants and types of the serial EEPROM write front end.
// Assumes a 50 MHz system clock and a page latch of 128 bytes.
package sew_pkg;

    localparam int CLK_HZ = 50000000;
    // Longest self-timed programming time, in milliseconds.
    localparam int PROG_TIME_MS = 5;
    // Longest time rounds down to whole cycles.
    localparam int PROG_CYCLES = (CLK_HZ / 1000) * PROG_TIME_MS;
    localparam int TIMER_W = 18;

    localparam int PAGE_AW = 7;
    localparam int PAGE_BYTES = 128;
    localparam int ADDR_W = 16;

    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [3:0] ACK_CLOCK = 4'h9;
    localparam int SYNC_W = 6;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEV = 7'h02,
        ST_WHI = 7'h04,
        ST_WLO = 7'h08,
        ST_DATA = 7'h10,
        ST_SKIP = 7'h20,
        ST_PROG = 7'h40
    } sew_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic write_control_pin;
        logic [2:0] chip_select;
    } sew_pins_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
    } sew_wr_t;

endpackage

// ---- verilog/sew_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps
module sew_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sew_sync_state_t;

    sew_sync_state_t s_q;
    sew_sync_state_t s_d;

    always_comb begin
        s_d.s1 = async_in;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Reset to the idle bus level, so no false edge follows reset.
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.s2;

endmodule

// ---- verilog/sew_page_mem.sv ----
// Page latch: 128 bytes, one write port and one read port with registered data.
// Assumes the caller never reads and writes the same byte in one cycle.
`timescale 1ns/1ps
module sew_page_mem
    import sew_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Write port
    input wire logic we,
    input wire logic [PAGE_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [PAGE_AW-1:0] raddr,
    output logic [7:0] rdata_q
);

    logic [7:0] mem [PAGE_BYTES];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

// ---- sim/sew_slave_assertions.sv ----
// Checker of the two-wire write slave, bound to its ports.
// Assumes the slave runs with the write time set by PROG_CYCLES_P.
`timescale 1ns/1ps
module sew_slave_assertions
    import sew_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus and straps
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_control_pin,
    input wire logic chip_select_bit0,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit2,
    // Array port and status
    input wire logic array_wr_en,
    input wire logic [ADDR_W-1:0] array_wr_addr,
    input wire logic [7:0] array_wr_data,
    input wire logic busy,
    input wire logic standby,
    input wire logic [ADDR_W-1:0] word_address_bits
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Counts the cycles of the current write cycle.
    logic [17:0] n_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) n_q <= 18'h0;
        else n_q <= busy ? n_q + 18'h1 : 18'h0;
    end
    sequence s_hold;
        busy [*8];
    endsequence
    oe_value_a: assert property (sda_out == 1'b0)
        else $error("data drive not low");
    quiet_busy_a: assert property (busy |-> !sda_oe)
        else $error("ack while busy");
    commit_busy_a: assert property (array_wr_en |-> busy)
        else $error("commit outside write cycle");
    commit_page_a: assert property (array_wr_en |->
        array_wr_addr[15:7] == word_address_bits[15:7])
        else $error("commit left the page");
    busy_hold_a: assert property ($rose(busy) |-> s_hold)
        else $error("write cycle too short");
    busy_cap_a: assert property (n_q <= PROG_CYCLES_P)
        else $error("write cycle too long");
    busy_end_a: assert property ($fell(busy) |-> standby && n_q == PROG_CYCLES_P)
        else $error("bad write cycle end");
    ack_stand_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("ack cut short");
    addr_hold_a: assert property (busy && $past(busy) |-> $stable(word_address_bits))
        else $error("counter moved while busy");
endmodule

bind sew_slave sew_slave_assertions #(.PROG_CYCLES_P(PROG_CYCLES_P)) chk_u (.*);

// ---- sim/sew_bus_master.sv ----
// Bus master model: start, stop, bytes and recovery on a 160 ns clock.
// Assumes calls at falling bench clock edges and a pull-up on data.
`timescale 1ns/1ps
module sew_bus_master (
    // Resolved data line
    input wire logic sda_line,
    // Driven lines, one means released
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        sda_drv = 1'b1;
        #40 scl = 1'b1;
        #80 sda_drv = 1'b0;
        #80 scl = 1'b0;
        #40;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #40 scl = 1'b1;
        #80 sda_drv = 1'b1;
        #80;
    endtask
    task automatic clk_bit(input logic d, output logic s);
        sda_drv = d;
        #40 scl = 1'b1;
        #40 s = sda_line;
        #40 scl = 1'b0;
        #40;
    endtask
    // Low time is stretched around the ack slot to cover the slave's lag.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        #80 clk_bit(1'b1, s);
        ack = ~s;
        #80;
    endtask
    task automatic recover();
        logic s;
        start();
        repeat (9) clk_bit(1'b1, s);
        start();
        stop();
    endtask
endmodule

// ---- sim/tb_serial_eeprom_bus_write_slave.sv ----
// Bench of the two-wire write slave: byte, page, protected, select,
// read and recovery traffic. Assumes a pull-up on the data line.
`timescale 1ns/1ps
module tb_serial_eeprom_bus_write_slave;
    import sew_pkg::*;
    localparam int PROG_P = 200;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wc = 1'b0;
    logic [2:0] cs = 3'h5;
    logic scl, sda_drv, sda_line, sda_oe, sda_out, wr_en, busy, standby, ack;
    logic [15:0] wr_addr, wa;
    logic [7:0] wr_data;
    logic [15:0] got_a[$];
    logic [7:0] got_d[$];
    int n_mismatch = 0;
    int check_count = 0;
    assign sda_line = sda_drv & (~sda_oe | sda_out);
    sew_bus_master mdl_u (.sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    sew_slave #(.PROG_CYCLES_P(PROG_P)) dut_u (.clock(clock), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .write_control_pin(wc),
        .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]),
        .array_wr_en(wr_en), .array_wr_addr(wr_addr), .array_wr_data(wr_data),
        .busy(busy), .standby(standby), .word_address_bits(wa));
    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        if (wr_en === 1'b1) begin
            got_a.push_back(wr_addr);
            got_d.push_back(wr_data);
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 400; i++) begin
            if (busy === lvl) return;
            @(negedge clock);
        end
        check(16'h0, 16'h1);
        give_verdict();
    endtask
    task automatic put(input logic [7:0] b, input logic exp);
        mdl_u.send_byte(b, ack);
        check(ack, exp);
    endtask
    task automatic hdr(input logic [15:0] a);
        got_a.delete();
        got_d.delete();
        mdl_u.start();
        put({DEV_TYPE, cs, 1'b0}, 1'b1);
        put(a[15:8], 1'b1);
        put(a[7:0], 1'b1);
    endtask
    task automatic t_byte();
        hdr(16'h1234);
        put(8'h5a, 1'b1);
        mdl_u.stop();
        wait_busy(1'b1);
        mdl_u.start();
        put({DEV_TYPE, cs, 1'b0}, 1'b0);
        mdl_u.stop();
        wait_busy(1'b0);
        check(16'(got_a.size()), 16'h1);
        check(got_a[0], 16'h1234);
        check(got_d[0], 8'h5a);
        check(wa, 16'h1235);
        check(standby, 1'b1);
        mdl_u.start();
        put({DEV_TYPE, cs, 1'b0}, 1'b1);
        mdl_u.stop();
    endtask
    task automatic t_page();
        logic [7:0] e;
        hdr(16'h2c7e);
        for (int i = 0; i < 130; i++) put(8'(i), 1'b1);
        mdl_u.stop();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check(16'(got_a.size()), 16'h80);
        for (int s = 0; s < 128; s++) begin
            e = 8'((s - 126) & 127);
            if (e < 8'h2) e = e + 8'h80;
            check(got_a[s], 16'h2c00 | 16'(s));
            check(got_d[s], e);
        end
        check(wa, 16'h2c00);
    endtask
    task automatic t_protect();
        wc = 1'b1;
        hdr(16'h0100);
        put(8'haa, 1'b1);
        mdl_u.stop();
        repeat (20) @(negedge clock);
        check(busy, 1'b0);
        check(16'(got_a.size()), 16'h0);
        wc = 1'b0;
    endtask
    task automatic t_select();
        for (int k = 0; k < 9; k++) begin
            mdl_u.start();
            put({((k < 8) ? DEV_TYPE : 4'hb), 3'(k), 1'b0}, k == 5);
            mdl_u.stop();
            repeat (8) @(negedge clock);
            check(standby, 1'b1);
        end
        mdl_u.start();
        put({DEV_TYPE, cs, 1'b1}, 1'b1);
        mdl_u.stop();
        repeat (8) @(negedge clock);
        check(standby, 1'b1);
        mdl_u.start();
        put({DEV_TYPE, cs, 1'b0}, 1'b1);
        put(8'h12, 1'b1);
        mdl_u.recover();
        mdl_u.start();
        put({DEV_TYPE, cs, 1'b0}, 1'b1);
        mdl_u.stop();
    endtask
    initial begin
        repeat (20) @(negedge clock);
        check(busy, 1'b0);
        check(standby, 1'b1);
        rst = 1'b0;
        repeat (6) @(negedge clock);
        t_byte();
        t_page();
        t_protect();
        t_select();
        give_verdict();
    end
endmodule
